// ==== design/cmic_defs.svh ====
`ifndef CMIC_DEFS_SVH
`define CMIC_DEFS_SVH
// register byte offsets
`define CMIC_OFS_STAT 5'h00
`define CMIC_OFS_SPDP 5'h04
`define CMIC_OFS_ACC 5'h08
`define CMIC_OFS_IDXX 5'h0c
`define CMIC_OFS_IDXY 5'h10
`define CMIC_OFS_CTRL 5'h14
// status flag positions
`define CMIC_P_N 7
`define CMIC_P_V 6
`define CMIC_P_M 5
`define CMIC_P_X 4
`define CMIC_P_D 3
`define CMIC_P_I 2
`define CMIC_P_Z 1
`define CMIC_P_C 0
// reset and forced values
`define CMIC_RST_P 8'h34
`define CMIC_SP_HI_EMU 8'h01
`define CMIC_RST_SP 16'h01ff
`define CMIC_BANK_ZERO 8'h00
`define CMIC_COP_RSV_BIT 7
`endif

// ==== design/cmic_pkg.sv ====
`default_nettype none
package cmic_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_CLR_STAT, OP_SET_STAT, OP_MODE, OP_MOVE_DEC, OP_MOVE_INC,
    OP_JMP_IND, OP_JML_IND, OP_JMP_IDX, OP_JSR_IDX, OP_BRK, OP_COP,
    OP_WAI, OP_STP, OP_XFER, OP_TAS, OP_TSA, OP_TAD, OP_TDA
  } cmic_op_e;
  typedef enum logic [1:0] {MD_NATIVE, MD_EMU16, MD_EMU8} cmic_mode_e;
  typedef enum logic [2:0] {ST_RUN, ST_WAIT, ST_STOP, ST_ABT1, ST_ABT2, ST_COLD} cmic_st_e;
  typedef enum logic [2:0] {
    VEC_NONE, VEC_COLD, VEC_ABORT, VEC_NMI, VEC_IRQ, VEC_BRK, VEC_COP
  } cmic_vec_e;
  typedef struct packed {
    cmic_op_e op;
    logic [15:0] aux;
    logic [31:0] data;
  } cmic_cmd_s;
  typedef struct packed {
    logic take;
    cmic_vec_e vec;
    logic push_pbr;
    logic [7:0] old_pbr;
    logic ret_wai;
    logic resume;
    logic cop_rsv;
  } cmic_evt_s;
  typedef struct packed {
    logic valid;
    logic dec;
    logic [23:0] src;
    logic [23:0] dst;
  } cmic_mv_s;
  typedef struct packed {
    logic valid;
    logic [7:0] bank;
  } cmic_jmp_s;
endpackage
`default_nettype wire

// ==== design/cmic_top.sv ====
`include "cmic_defs.svh"
`default_nettype none
module cmic_top
  import cmic_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic cold_start_n, // cold start pin
  input wire logic cancel_instr_n, // abort pin
  input wire logic unmaskable_irq_n, // nmi pin
  input wire logic maskable_int_n, // irq pin
  input wire logic rdy_in, // external ready pin
  input wire logic bus_wr_i, // core is in a write cycle
  input wire logic cmd_valid_i, // command offered by core
  input wire cmic_cmd_s cmd_i, // command, operand and source value
  output logic cmd_rdy_o, // command accepted when valid
  output cmic_evt_s evt_o, // interrupt event, one-cycle take
  output cmic_mv_s mv_o, // block move addresses, one-cycle valid
  output cmic_jmp_s jmp_o, // indirect pointer bank, one-cycle valid
  output logic ready_o, // ready line driven by the core
  output logic clk_run_o, // main_clock gate enable
  output logic bank_mux_o, // bank address multiplex enable
  output logic bus_hold_o, // data bus held in transfer state
  output logic stall_o, // core stall request
  input wire logic [2:0] avs_address, // avalon word address
  input wire logic avs_read, // avalon read
  input wire logic avs_write, // avalon write
  input wire logic [31:0] avs_writedata, // avalon write data
  output logic [31:0] avs_readdata, // avalon read data
  output logic avs_waitrequest // avalon wait request
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers; edges are taken from stage two and three only
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 5'h1f;
      s2_r <= 5'h1f;
      s3_r <= 5'h1f;
    end else begin
      s1_r <= {cold_start_n, cancel_instr_n, unmaskable_irq_n, maskable_int_n, rdy_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic cold_s;
  logic cold_fall;
  logic abt_fall;
  logic nmi_fall;
  logic irq_act;
  logic rdy_s;
  assign cold_s = s2_r[4];
  assign cold_fall = s3_r[4] & ~s2_r[4];
  assign abt_fall = s3_r[3] & ~s2_r[3];
  assign nmi_fall = s3_r[2] & ~s2_r[2];
  // irq level lags one stage so a latched nmi or abort outranks a simultaneous irq
  assign irq_act = ~s2_r[1] & ~s3_r[1];
  assign rdy_s = s2_r[0];

  ////////////////////////////////////////////////////////////////////
  // architectural state
  cmic_st_e st_r;
  cmic_st_e st_nxt;
  cmic_mode_e mode_r;
  logic [7:0] p_r;
  logic [7:0] p_nxt;
  logic [7:0] pbr_r;
  logic [7:0] dbr_r;
  logic [31:0] acc_r;
  logic [31:0] x_r;
  logic [31:0] y_r;
  logic [15:0] sp_r;
  logic [15:0] dp_r;
  logic abt_pend_r;
  logic nmi_pend_r;
  logic wai_ret_r;
  logic cmd_rdy_r;
  logic fire;
  logic take;
  cmic_vec_e vec;
  logic resume;
  logic abt_wai;
  logic emu;
  logic wr_ctrl;

  assign fire = cmd_valid_i & cmd_rdy_r;
  assign emu = (mode_r != MD_NATIVE);

  // byte offset match, shared by read and write decode
  function automatic logic hit(input logic [2:0] a, input logic [4:0] ofs);
    hit = ({a, 2'b00} == ofs);
  endfunction

  // nz flags for a value of the given width
  function automatic logic [1:0] nz(input logic [31:0] v, input logic [1:0] w);
    case (w)
      2'h0: nz = {v[7], v[7:0] == 8'h00};
      2'h1: nz = {v[15], v[15:0] == 16'h0000};
      default: nz = {v[31], v == 32'h0000_0000};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // sequencer: command boundary, wait, stop, abort and cold start
  always_comb begin
    st_nxt = st_r;
    take = 1'b0;
    vec = VEC_NONE;
    resume = 1'b0;
    abt_wai = 1'b0;
    case (st_r)
      ST_RUN: begin
        // a command at the boundary defers interrupts by one cycle
        if (fire) begin
          case (cmd_i.op)
            OP_WAI: st_nxt = ST_WAIT;
            OP_STP: st_nxt = ST_STOP;
            OP_BRK: begin
              take = 1'b1;
              vec = VEC_BRK;
            end
            OP_COP: begin
              take = 1'b1;
              vec = VEC_COP;
            end
            default: st_nxt = ST_RUN;
          endcase
        end else if (abt_pend_r) begin
          st_nxt = ST_ABT1;
        end else if (nmi_pend_r) begin
          take = 1'b1;
          vec = VEC_NMI;
        end else if (irq_act && !p_r[`CMIC_P_I]) begin
          take = 1'b1;
          vec = VEC_IRQ;
        end
      end
      ST_WAIT: begin
        if (abt_pend_r) begin
          st_nxt = ST_ABT1;
          abt_wai = 1'b1;
        end else if (nmi_pend_r) begin
          st_nxt = ST_RUN;
          take = 1'b1;
          vec = VEC_NMI;
        end else if (irq_act) begin
          st_nxt = ST_RUN;
          if (p_r[`CMIC_P_I]) begin
            resume = 1'b1;
          end else begin
            take = 1'b1;
            vec = VEC_IRQ;
          end
        end
      end
      ST_ABT1: st_nxt = ST_ABT2;
      ST_ABT2: begin
        st_nxt = ST_RUN;
        take = 1'b1;
        vec = VEC_ABORT;
      end
      ST_STOP: st_nxt = ST_STOP;
      ST_COLD: begin
        if (cold_s) begin
          st_nxt = ST_RUN;
          take = 1'b1;
          vec = VEC_COLD;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
    // cold start outranks everything and is the only way out of stop
    if (cold_fall) begin
      st_nxt = ST_COLD;
      take = 1'b0;
      vec = VEC_NONE;
      resume = 1'b0;
      abt_wai = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RUN;
      cmd_rdy_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cmd_rdy_r <= (st_nxt == ST_RUN);
    end
  end

  // pending latches; a new edge wins over the clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      abt_pend_r <= 1'b0;
      nmi_pend_r <= 1'b0;
      wai_ret_r <= 1'b0;
    end else begin
      if (abt_fall) begin
        abt_pend_r <= 1'b1;
      end else if (st_r == ST_ABT2) begin
        abt_pend_r <= 1'b0;
      end
      if (nmi_fall) begin
        nmi_pend_r <= 1'b1;
      end else if (take && vec == VEC_NMI) begin
        nmi_pend_r <= 1'b0;
      end
      if (abt_wai) begin
        wai_ret_r <= 1'b1;
      end else if (take && vec == VEC_ABORT) begin
        wai_ret_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MD_EMU8;
    end else if (take && vec == VEC_COLD) begin
      mode_r <= MD_EMU8;
    end else if (fire && cmd_i.op == OP_MODE) begin
      case (cmd_i.aux[1:0])
        2'h1: mode_r <= MD_EMU16;
        2'h2: mode_r <= MD_EMU8;
        default: mode_r <= MD_NATIVE;
      endcase
    end
  end

  // status flags; software write of I is applied first so hardware wins
  always_comb begin
    p_nxt = p_r;
    if (wr_ctrl) begin
      p_nxt[`CMIC_P_I] = avs_writedata[0];
    end
    if (fire) begin
      case (cmd_i.op)
        OP_CLR_STAT: p_nxt = p_nxt & ~cmd_i.aux[7:0];
        OP_SET_STAT: p_nxt = p_nxt | cmd_i.aux[7:0];
        OP_MODE: begin
          if (cmd_i.aux[1:0] != 2'h0 && cmd_i.aux[1:0] != 2'h3) begin
            p_nxt[`CMIC_P_M] = 1'b1;
            p_nxt[`CMIC_P_X] = 1'b1;
          end
        end
        OP_XFER: begin
          case (cmd_i.aux[1:0])
            2'h0: {p_nxt[`CMIC_P_N], p_nxt[`CMIC_P_Z]} =
                nz(cmd_i.data, p_r[`CMIC_P_M] ? 2'h0 : 2'h2);
            default: {p_nxt[`CMIC_P_N], p_nxt[`CMIC_P_Z]} =
                nz(cmd_i.data, p_r[`CMIC_P_X] ? 2'h0 : 2'h2);
          endcase
        end
        OP_TSA: {p_nxt[`CMIC_P_N], p_nxt[`CMIC_P_Z]} = nz({16'h0000, sp_r}, 2'h1);
        OP_TDA: {p_nxt[`CMIC_P_N], p_nxt[`CMIC_P_Z]} = nz({16'h0000, dp_r}, 2'h1);
        default: p_nxt = p_nxt;
      endcase
    end
    if (take) begin
      p_nxt[`CMIC_P_D] = 1'b0;
      p_nxt[`CMIC_P_I] = 1'b1;
      if (vec == VEC_COLD) begin
        p_nxt = `CMIC_RST_P;
      end
    end
    // emulation pins M and X high whatever the command asked
    if (emu) begin
      p_nxt[`CMIC_P_M] = 1'b1;
      p_nxt[`CMIC_P_X] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      p_r <= `CMIC_RST_P;
    end else begin
      p_r <= p_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // program and data bank
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pbr_r <= `CMIC_BANK_ZERO;
      dbr_r <= `CMIC_BANK_ZERO;
    end else if (take) begin
      pbr_r <= `CMIC_BANK_ZERO;
      if (emu || vec == VEC_COLD) begin
        dbr_r <= `CMIC_BANK_ZERO;
      end
    end else if (fire && (cmd_i.op == OP_MOVE_DEC || cmd_i.op == OP_MOVE_INC)) begin
      dbr_r <= cmd_i.aux[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // accumulator, index, stack and direct registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= 32'h0000_0000;
      x_r <= 32'h0000_0000;
      y_r <= 32'h0000_0000;
      sp_r <= `CMIC_RST_SP;
      dp_r <= 16'h0000;
    end else if (take && vec == VEC_COLD) begin
      sp_r[15:8] <= `CMIC_SP_HI_EMU;
      x_r[31:8] <= 24'h000000;
      y_r[31:8] <= 24'h000000;
      dp_r <= 16'h0000;
    end else if (fire) begin
      case (cmd_i.op)
        OP_MODE: begin
          // only the high parts change; low bytes and acc stay put
          if (!emu && cmd_i.aux[1:0] != 2'h0 && cmd_i.aux[1:0] != 2'h3) begin
            sp_r[15:8] <= `CMIC_SP_HI_EMU;
            x_r[31:8] <= 24'h000000;
            y_r[31:8] <= 24'h000000;
          end
        end
        OP_XFER: begin
          case (cmd_i.aux[1:0])
            2'h0: acc_r <= p_r[`CMIC_P_M] ? {acc_r[31:8], cmd_i.data[7:0]}
                : cmd_i.data;
            2'h1: x_r <= p_r[`CMIC_P_X] ? {24'h000000, cmd_i.data[7:0]} : cmd_i.data;
            default: y_r <= p_r[`CMIC_P_X] ? {24'h000000, cmd_i.data[7:0]}
                : cmd_i.data;
          endcase
        end
        OP_TAS: sp_r <= (mode_r == MD_EMU8) ? {`CMIC_SP_HI_EMU, acc_r[7:0]}
            : acc_r[15:0];
        OP_TSA: acc_r[15:0] <= sp_r;
        OP_TAD: dp_r <= acc_r[15:0];
        OP_TDA: acc_r[15:0] <= dp_r;
        default: acc_r <= acc_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt event report
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_o <= '0;
    end else begin
      evt_o.take <= take;
      evt_o.vec <= vec;
      evt_o.push_pbr <= take && !emu && vec != VEC_COLD;
      evt_o.old_pbr <= pbr_r;
      evt_o.ret_wai <= take && vec == VEC_ABORT && wai_ret_r;
      evt_o.resume <= resume;
      evt_o.cop_rsv <= take && vec == VEC_COP
          && cmd_i.aux[`CMIC_COP_RSV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // block move addresses and indirect pointer bank
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mv_o <= '0;
      jmp_o <= '0;
    end else begin
      mv_o.valid <= fire && (cmd_i.op == OP_MOVE_DEC || cmd_i.op == OP_MOVE_INC);
      mv_o.dec <= (cmd_i.op == OP_MOVE_DEC);
      // emulation keeps both pointers inside the first page
      mv_o.src <= emu ? {cmd_i.aux[15:8], 8'h00, x_r[7:0]}
          : {cmd_i.aux[15:8], x_r[15:0]};
      mv_o.dst <= emu ? {cmd_i.aux[7:0], 8'h00, y_r[7:0]}
          : {cmd_i.aux[7:0], y_r[15:0]};
      jmp_o.valid <= fire && (cmd_i.op == OP_JMP_IND || cmd_i.op == OP_JML_IND
          || cmd_i.op == OP_JMP_IDX || cmd_i.op == OP_JSR_IDX);
      jmp_o.bank <= (cmd_i.op == OP_JMP_IDX || cmd_i.op == OP_JSR_IDX) ? pbr_r
          : `CMIC_BANK_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin-side controls: ready, clock gate, bus hold, stall
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_o <= 1'b1;
      clk_run_o <= 1'b1;
      bank_mux_o <= 1'b1;
      bus_hold_o <= 1'b0;
      stall_o <= 1'b0;
    end else begin
      ready_o <= (st_nxt != ST_WAIT);
      // clock only comes back on the cold start edge, never on nmi or irq
      if (cold_fall) begin
        clk_run_o <= 1'b1;
      end else if (st_nxt == ST_STOP) begin
        clk_run_o <= 1'b0;
      end
      bank_mux_o <= (st_nxt != ST_STOP);
      bus_hold_o <= (st_nxt == ST_STOP) || (st_nxt == ST_WAIT);
      stall_o <= !rdy_s && !(bus_wr_i && emu);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the access completes
  logic acc_go;
  assign acc_go = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_ctrl = acc_go & avs_write & hit(avs_address, `CMIC_OFS_CTRL);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read | avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        if (hit(avs_address, `CMIC_OFS_STAT)) begin
          avs_readdata <= {dbr_r, pbr_r, p_r, 1'b0, nmi_pend_r, abt_pend_r, mode_r, st_r};
        end else if (hit(avs_address, `CMIC_OFS_SPDP)) begin
          avs_readdata <= {dp_r, sp_r};
        end else if (hit(avs_address, `CMIC_OFS_ACC)) begin
          avs_readdata <= acc_r;
        end else if (hit(avs_address, `CMIC_OFS_IDXX)) begin
          avs_readdata <= x_r;
        end else if (hit(avs_address, `CMIC_OFS_IDXY)) begin
          avs_readdata <= y_r;
        end else if (hit(avs_address, `CMIC_OFS_CTRL)) begin
          avs_readdata <= {31'h0000_0000, p_r[`CMIC_P_I]};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  assign cmd_rdy_o = cmd_rdy_r;

endmodule
`default_nettype wire

// ==== bench/cmic_checker.sv ====
`default_nettype none
module cmic_checker
  import cmic_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic cold_start_n, // cold start pin
  input wire logic rdy_in, // external ready pin
  input wire logic cmd_valid_i, // command offered
  input wire cmic_cmd_s cmd_i, // command
  input wire logic cmd_rdy_o, // command accepted
  input wire cmic_evt_s evt_o, // interrupt event
  input wire cmic_mv_s mv_o, // block move addresses
  input wire cmic_jmp_s jmp_o, // pointer bank
  input wire logic ready_o, // ready line
  input wire logic clk_run_o, // clock gate enable
  input wire logic bank_mux_o, // bank multiplex enable
  input wire logic bus_hold_o, // data bus hold
  input wire logic stall_o // core stall
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // a command counts only on the edge where both sides agree
  assign take = cmd_valid_i && cmd_rdy_o;
  ////////////////////////////////////////////////////////////////////////////////
  AST_BRK_EVT: assert property (take && cmd_i.op == OP_BRK |=>
    evt_o.take && evt_o.vec == VEC_BRK && !evt_o.cop_rsv) else $error("break event wrong");
  AST_JMP_BANK: assert property (take && (cmd_i.op == OP_JMP_IND || cmd_i.op == OP_JML_IND)
    |=> jmp_o.valid && jmp_o.bank == 8'h00) else $error("indirect bank not zero");
  AST_MV_DST: assert property (take && (cmd_i.op == OP_MOVE_INC || cmd_i.op == OP_MOVE_DEC)
    |=> mv_o.valid && mv_o.dst[23:16] == $past(cmd_i.aux[7:0])
    && mv_o.dec == ($past(cmd_i.op) == OP_MOVE_DEC)) else $error("move bank wrong");
  AST_COP_SIG: assert property (take && cmd_i.op == OP_COP |=>
    evt_o.vec == VEC_COP && evt_o.cop_rsv == $past(cmd_i.aux[7])) else $error("trap sig wrong");
  AST_WAI_LOW: assert property (take && cmd_i.op == OP_WAI |=>
    !ready_o && bus_hold_o && !cmd_rdy_o) else $error("wait did not drop ready");
  AST_STP_GATE: assert property (take && cmd_i.op == OP_STP |=>
    (!clk_run_o && !bank_mux_o && bus_hold_o) [*2]) else $error("stop did not gate");
  AST_COLD_ONLY: assert property ($rose(clk_run_o) |-> !$past(cold_start_n, 1)
    || !$past(cold_start_n, 2) || !$past(cold_start_n, 3) || !$past(cold_start_n, 4))
    else $error("clock restarted without cold start");
  AST_STALL_FREE: assert property (rdy_in [*4] |=> !stall_o)
    else $error("stall while ready");
  AST_EVT_QUAL: assert property (!evt_o.take |->
    !evt_o.push_pbr && !evt_o.cop_rsv && !evt_o.ret_wai) else $error("event fields loose");
endmodule
bind cmic_top cmic_checker u_chk (.*);
`default_nettype wire

// ==== bench/cmic_pin_model.sv ====
`default_nettype none
module cmic_pin_model (
  input wire logic clk_sys, // system clock
  input wire logic [4:0] hold, // requests: cold, cancel, nmi, irq, not ready
  output logic cold_start_n, // cold start pin
  output logic cancel_instr_n, // abort pin
  output logic unmaskable_irq_n, // nmi pin
  output logic maskable_int_n, // irq pin
  output logic rdy_in // ready pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] held = 5'h00;
  // sources act one edge late, like slow external logic
  always @(posedge clk_sys) begin
    held <= hold;
  end
  // pulled-up lines: a released request reads high, never a stale level
  // the oscillator never stops here, so a cold start release meets a stable clock
  assign {rdy_in, maskable_int_n, unmaskable_irq_n, cancel_instr_n, cold_start_n} = ~held;
endmodule
`default_nettype wire

// ==== bench/cmic_top_tb.sv ====
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  $display("BAD %s exp %h got %h", nm, ex, got); bad_count++; end end
module cmic_top_tb
  import cmic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_n = 1'b0, bus_wr_i = 1'b0, cmd_valid_i = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, cmd_rdy_o, ready_o, clk_run_o, bank_mux_o, bus_hold_o, stall_o;
  logic cold_start_n, cancel_instr_n, unmaskable_irq_n, maskable_int_n, rdy_in;
  logic [4:0] hold = 5'h00;
  cmic_cmd_s cmd_i = '0;
  cmic_evt_s evt_o;
  cmic_mv_s mv_o;
  cmic_jmp_s jmp_o;
  int bad_count = 0, check_count = 0, cycles = 0;
  cmic_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cold_start_n(cold_start_n),
    .cancel_instr_n(cancel_instr_n), .unmaskable_irq_n(unmaskable_irq_n),
    .maskable_int_n(maskable_int_n), .rdy_in(rdy_in), .bus_wr_i(bus_wr_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_rdy_o(cmd_rdy_o), .evt_o(evt_o),
    .mv_o(mv_o), .jmp_o(jmp_o), .ready_o(ready_o), .clk_run_o(clk_run_o),
    .bank_mux_o(bank_mux_o), .bus_hold_o(bus_hold_o), .stall_o(stall_o),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  cmic_pin_model u_pins (.clk_sys(clk_sys), .hold(hold), .cold_start_n(cold_start_n),
    .cancel_instr_n(cancel_instr_n), .unmaskable_irq_n(unmaskable_irq_n),
    .maskable_int_n(maskable_int_n), .rdy_in(rdy_in));
  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock and a cycle ceiling well above the few hundred cycles needed
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // avalon access: request held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // command held until taken; returns at the edge where the pulse outputs stand
  task automatic go(input cmic_op_e op, input logic [15:0] aux, input logic [31:0] d);
    @(posedge clk_sys);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op, aux, d};
    do @(posedge clk_sys); while (cmd_rdy_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  // bounded wait for a take or resume pulse
  task automatic wait_evt();
    int n;
    n = 0;
    do begin @(posedge clk_sys); n++; end
    while (evt_o.take !== 1'b1 && evt_o.resume !== 1'b1 && n < 60);
    `CHK("evt seen", 1'b1, n < 60)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    avs(1'b0, 3'h0, 32'h0); `CHK("stat", 32'h0000_3410, q) // flags
    avs(1'b0, 3'h1, 32'h0); `CHK("sp", 32'h0000_01ff, q)
    avs(1'b1, 3'h7, 32'hffff_ffff);
    avs(1'b0, 3'h7, 32'h0); `CHK("unmapped", 32'h0, q)
  endtask
  task automatic t_emu();
    go(OP_CLR_STAT, 16'h0030, 32'h0);
    go(OP_SET_STAT, 16'h0008, 32'h0);
    go(OP_MOVE_INC, 16'h1256, 32'h0);
    `CHK("mv", {2'b10, 24'h120000, 24'h560000}, mv_o) // page zero
    avs(1'b0, 3'h0, 32'h0); `CHK("dbr p", 16'h563c, {q[31:24], q[15:8]}) // bits
    go(OP_BRK, 16'h0, 32'h0);
    `CHK("brk", {1'b1, VEC_BRK, 1'b0}, {evt_o.take, evt_o.vec, evt_o.push_pbr}) // no push
    avs(1'b0, 3'h0, 32'h0); `CHK("banks p", 24'h000034, q[31:8]) // clear
  endtask
  task automatic t_mode();
    go(OP_MODE, 16'h0, 32'h0);
    go(OP_CLR_STAT, 16'h0030, 32'h0);
    go(OP_XFER, 16'h0, 32'h9abc_def0); // stack transfers read the accumulator
    go(OP_TAS, 16'h0, 32'h0);
    go(OP_XFER, 16'h0, 32'h0000_0000); // so the copy back is visible
    go(OP_TSA, 16'h0, 32'h0);
    avs(1'b0, 3'h1, 32'h0); `CHK("sp nat", 16'hdef0, q[15:0]) // width
    avs(1'b0, 3'h2, 32'h0); `CHK("tsa nat", 16'hdef0, q[15:0]) // copy
    go(OP_XFER, 16'h0, 32'h1122_3344);
    go(OP_XFER, 16'h1, 32'h5566_a7b8);
    go(OP_MODE, 16'h2, 32'h0);
    avs(1'b0, 3'h0, 32'h0); `CHK("p emu", 8'h34, q[15:8]) // set
    avs(1'b0, 3'h1, 32'h0); `CHK("sp emu", 16'h01f0, q[15:0])
    avs(1'b0, 3'h2, 32'h0); `CHK("acc", 32'h1122_3344, q)
    avs(1'b0, 3'h3, 32'h0); `CHK("x emu", 16'h00b8, q[15:0]) // high
    go(OP_XFER, 16'h0, 32'h0000_1234);
    go(OP_TAS, 16'h0, 32'h0);
    go(OP_TSA, 16'h0, 32'h0);
    avs(1'b0, 3'h1, 32'h0); `CHK("sp emu8", 16'h0134, q[15:0]) // forced
    avs(1'b0, 3'h2, 32'h0); `CHK("tsa emu8", 16'h0134, q[15:0]) // copy
  endtask
  task automatic t_native();
    cmic_op_e jop[4] = '{OP_JMP_IND, OP_JML_IND, OP_JMP_IDX, OP_JSR_IDX};
    go(OP_MODE, 16'h0, 32'h0);
    go(OP_MOVE_DEC, 16'h1256, 32'h0); `CHK("mv dec", 2'b11, {mv_o.valid, mv_o.dec}) // dir
    go(OP_BRK, 16'h0, 32'h0);
    `CHK("brk nat", 10'h300, {evt_o.take, evt_o.push_pbr, evt_o.old_pbr}) // push
    avs(1'b0, 3'h0, 32'h0); `CHK("dbr nat", 16'h5600, q[31:16])
    for (int i = 0; i < 4; i++) begin
      go(jop[i], 16'h0, 32'h0); `CHK("jmp", 9'h100, jmp_o) // bank
    end
    go(OP_COP, 16'h007f, 32'h0); `CHK("cop usr", {VEC_COP, 1'b0}, {evt_o.vec, evt_o.cop_rsv}) // sig
    go(OP_COP, 16'h0080, 32'h0); `CHK("cop rsv", {VEC_COP, 1'b1}, {evt_o.vec, evt_o.cop_rsv}) // sig
  endtask
  task automatic t_wait();
    avs(1'b1, 3'h5, 32'h0);
    go(OP_WAI, 16'h0, 32'h0); `CHK("wai", 3'b010, {ready_o, bus_hold_o, cmd_rdy_o}) // low
    hold <= 5'h08;
    wait_evt(); `CHK("irq", {1'b1, VEC_IRQ}, {evt_o.take, evt_o.vec}) // vector
    hold <= 5'h00;
    @(posedge clk_sys); `CHK("ready", 1'b1, ready_o) // back
    go(OP_WAI, 16'h0, 32'h0);
    hold <= 5'h08;
    wait_evt(); `CHK("resume", 2'b01, {evt_o.take, evt_o.resume}) // masked
    hold <= 5'h00;
    // a stale synced irq level would end the next wait at once
    repeat (3) @(posedge clk_sys);
    go(OP_WAI, 16'h0, 32'h0);
    hold <= 5'h02;
    @(posedge clk_sys);
    hold <= 5'h00;
    wait_evt(); `CHK("abort", {1'b1, VEC_ABORT, 1'b1}, {evt_o.take, evt_o.vec, evt_o.ret_wai})
    avs(1'b0, 3'h0, 32'h0); `CHK("abt latch", 1'b0, q[5]) // cleared
  endtask
  task automatic t_prio();
    avs(1'b1, 3'h5, 32'h0);
    go(OP_WAI, 16'h0, 32'h0);
    hold <= 5'h0c;
    wait_evt(); `CHK("nmi first", VEC_NMI, evt_o.vec) // order
    hold <= 5'h03;
    repeat (6) @(posedge clk_sys);
    hold <= 5'h00;
    wait_evt(); `CHK("cold first", VEC_COLD, evt_o.vec) // order
  endtask
  task automatic t_stop();
    int n;
    go(OP_STP, 16'h0, 32'h0); `CHK("stop", 3'b001, {clk_run_o, bank_mux_o, bus_hold_o})
    hold <= 5'h0c;
    repeat (8) @(posedge clk_sys); `CHK("stopped", 1'b0, clk_run_o) // only cold
    hold <= 5'h01;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (clk_run_o !== 1'b1 && n < 20);
    `CHK("restart", 1'b1, clk_run_o) // cold
    hold <= 5'h00;
    wait_evt(); `CHK("cold vec", VEC_COLD, evt_o.vec) // vector
  endtask
  task automatic t_stall();
    hold <= 5'h10;
    bus_wr_i <= 1'b1;
    repeat (6) @(posedge clk_sys); `CHK("emu wr", 1'b0, stall_o) // no stall
    bus_wr_i <= 1'b0;
    repeat (4) @(posedge clk_sys); `CHK("emu rd", 1'b1, stall_o) // stall
    go(OP_MODE, 16'h0, 32'h0);
    bus_wr_i <= 1'b1;
    repeat (4) @(posedge clk_sys); `CHK("nat wr", 1'b1, stall_o) // stall
    hold <= 5'h00;
    bus_wr_i <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: each step starts from the state the previous one left
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_emu();
    t_mode();
    t_native();
    t_wait();
    t_prio();
    t_stop();
    t_stall();
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire
